// ### hdl/pea_pkg.sv
package pea_pkg;
    // ========================================
    // register map
    localparam logic [7:0] OFS_SETUP = 8'h00;
    localparam logic [7:0] OFS_DIP_LIM = 8'h04;
    localparam logic [7:0] OFS_SWELL_LIM = 8'h08;
    localparam logic [7:0] OFS_CUR_LIM = 8'h0c;
    localparam logic [7:0] OFS_POW_LIM = 8'h10;
    localparam logic [7:0] OFS_HEAT_LIM = 8'h14;
    localparam logic [7:0] OFS_SAVE_LVL = 8'h18;
    localparam logic [7:0] OFS_RESTORE_LVL = 8'h1c;
    localparam logic [7:0] OFS_STATUS = 8'h20;
    localparam logic [7:0] OFS_MEAN = 8'h24;
    // ========================================
    // setup register fields
    localparam logic [31:0] SETUP_RW_MASK = 32'h1bffc0ff;
    localparam logic [31:0] SETUP_CLR_MASK = 32'h04000f00;
    localparam logic [31:0] SETUP_RESET = 32'h00000000;
    localparam int NUM_EV = 5;
    localparam int EV_CUR = 0;
    localparam int EV_POW = 1;
    localparam int EV_DIP = 2;
    localparam int EV_SWELL = 3;
    localparam int EV_HEAT = 4;
    // bit positions per event, 5 bits each, event 0 lowest
    localparam logic [24:0] POS_SIM = {5'h18, 5'h03, 5'h02, 5'h01, 5'h00};
    localparam logic [24:0] POS_LATCH = {5'h19, 5'h07, 5'h06, 5'h05, 5'h04};
    localparam logic [24:0] POS_CLR = {5'h1a, 5'h09, 5'h08, 5'h0a, 5'h0b};
    localparam logic [24:0] POS_OUT1 = {5'h1b, 5'h11, 5'h10, 5'h13, 5'h12};
    localparam logic [24:0] POS_OUT2 = {5'h1c, 5'h15, 5'h14, 5'h17, 5'h16};
    localparam int OUT1_MANUAL_BIT = 14;
    localparam int OUT2_MANUAL_BIT = 15;
    // ========================================
    // status register fields
    localparam int ST_OUT1_BIT = 5;
    localparam int ST_OUT2_BIT = 6;
    localparam int ST_PWR_BIT = 7;
    localparam int HEAT_W = 10;
    // ========================================
    // bus answers
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [0:0] {
        PWR_DOWN = 1'b0,
        PWR_UP = 1'b1
    } pea_pwr_e;
endpackage : pea_pkg

// ### hdl/pea_power_event_alarm_unit.sv
`timescale 1ns/1ps
`default_nettype none
module pea_power_event_alarm_unit #(
    parameter int SAMPLE_RATE_HZ = 4000,
    parameter int LINE_HZ = 50,
    parameter int SAMPLE_W = 16
) (
    // clock and reset
    input wire logic mclk_i,
    input wire logic rst_n_i,
    // measurement engine
    input wire logic sample_valid_i,
    input wire logic signed [SAMPLE_W-1:0] volt_sample_i,
    input wire logic calc_done_i,
    input wire logic [31:0] volts_rms_i,
    input wire logic [31:0] current_rms_i,
    input wire logic [31:0] active_power_i,
    input wire logic [pea_pkg::HEAT_W-1:0] heat_code_i,
    // event outputs and counter storage
    output logic alarm_out1_o,
    output logic alarm_out2_o,
    output logic save_start_o,
    output logic restore_start_o,
    // axi4-lite write
    input wire logic [7:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    // axi4-lite read
    input wire logic [7:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i
);
    // ========================================
    // window sizing
    localparam int WIN = SAMPLE_RATE_HZ / (2 * LINE_HZ);
    localparam int PTR_W = (WIN > 1) ? $clog2(WIN) : 1;
    localparam int SQ_W = 2 * SAMPLE_W;
    localparam int SUM_W = SQ_W + PTR_W + 1;
    localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(WIN - 1);

    if (WIN < 1 || WIN > 1024 || SAMPLE_W < 2 || SAMPLE_W > 16) begin : g_chk
        $error("pea: window or sample width out of range");
    end

    // ========================================
    // helpers
    function automatic logic [4:0] pick(input logic [31:0] v, input logic [24:0] pos);
        logic [4:0] r;
        r = '0;
        for (int i = 0; i < pea_pkg::NUM_EV; i++) begin
            r[i] = v[pos[5*i +: 5]];
        end
        return r;
    endfunction : pick

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                          input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                r[8*b +: 8] = d[8*b +: 8];
            end
        end
        return r;
    endfunction : merge

    function automatic logic [SUM_W-1:0] scale(input logic [31:0] lim);
        return SUM_W'(lim) * SUM_W'(WIN);
    endfunction : scale

    // ========================================
    // registers
    logic [31:0] setup_reg;
    logic [31:0] dip_lim_reg;
    logic [31:0] swell_lim_reg;
    logic [31:0] cur_lim_reg;
    logic [31:0] pow_lim_reg;
    logic [pea_pkg::HEAT_W-1:0] heat_lim_reg;
    logic [31:0] save_lvl_reg;
    logic [31:0] restore_lvl_reg;
    logic [4:0] cond_reg;
    logic [4:0] flag_reg;
    logic [4:0] flag_next;
    logic [SQ_W-1:0] win_mem [WIN];
    logic [PTR_W-1:0] ptr_reg;
    logic full_reg;
    logic [SUM_W-1:0] sum_reg;
    pea_pkg::pea_pwr_e pwr_reg;
    logic [7:0] awaddr_reg;
    logic aw_full_reg;
    logic [31:0] wdata_reg;
    logic [3:0] wstrb_reg;
    logic w_full_reg;

    // ========================================
    // trailing mean square of voltage
    wire logic signed [SQ_W-1:0] sq_s = volt_sample_i * volt_sample_i;
    wire logic [SQ_W-1:0] oldest = full_reg ? win_mem[ptr_reg] : '0;
    wire logic [SUM_W-1:0] sum_next = sum_reg + SUM_W'($unsigned(sq_s)) - SUM_W'(oldest);
    wire logic dip_now = sum_next < scale(dip_lim_reg);
    wire logic swell_now = sum_next > scale(swell_lim_reg);
    wire logic [31:0] mean_sq = 32'(sum_reg / SUM_W'(WIN));

    always_ff @(posedge mclk_i) begin
        if (sample_valid_i) begin
            win_mem[ptr_reg] <= $unsigned(sq_s);
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            ptr_reg <= '0;
            full_reg <= 1'b0;
            sum_reg <= '0;
        end else if (sample_valid_i) begin
            ptr_reg <= (ptr_reg == PTR_LAST) ? '0 : ptr_reg + 1'b1;
            full_reg <= full_reg | (ptr_reg == PTR_LAST);
            sum_reg <= sum_next;
        end
    end

    // ========================================
    // limit comparisons
    wire logic cur_now = current_rms_i > cur_lim_reg;
    wire logic pow_now = active_power_i > pow_lim_reg;
    wire logic heat_now = heat_code_i > heat_lim_reg;

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            cond_reg <= '0;
        end else begin
            if (sample_valid_i) begin
                cond_reg[pea_pkg::EV_DIP] <= dip_now;
                cond_reg[pea_pkg::EV_SWELL] <= swell_now;
            end
            if (calc_done_i) begin
                cond_reg[pea_pkg::EV_CUR] <= cur_now;
                cond_reg[pea_pkg::EV_POW] <= pow_now;
                cond_reg[pea_pkg::EV_HEAT] <= heat_now;
            end
        end
    end

    // ========================================
    // bus write decode
    wire logic wr_go = aw_full_reg && w_full_reg && !s_axi_bvalid_o;
    wire logic [31:0] wr_setup = merge(setup_reg, wdata_reg, wstrb_reg);
    wire logic wr_hit_setup = wr_go && awaddr_reg == pea_pkg::OFS_SETUP;
    wire logic [31:0] clr_bits = wr_hit_setup ? (wr_setup & pea_pkg::SETUP_CLR_MASK) : '0;
    wire logic wr_mapped = awaddr_reg == pea_pkg::OFS_SETUP
        || awaddr_reg == pea_pkg::OFS_DIP_LIM || awaddr_reg == pea_pkg::OFS_SWELL_LIM
        || awaddr_reg == pea_pkg::OFS_CUR_LIM || awaddr_reg == pea_pkg::OFS_POW_LIM
        || awaddr_reg == pea_pkg::OFS_HEAT_LIM || awaddr_reg == pea_pkg::OFS_SAVE_LVL
        || awaddr_reg == pea_pkg::OFS_RESTORE_LVL;

    // ========================================
    // event flags
    wire logic [4:0] ev_sim = pick(setup_reg, pea_pkg::POS_SIM);
    wire logic [4:0] ev_latch = pick(setup_reg, pea_pkg::POS_LATCH);
    wire logic [4:0] ev_clr = pick(clr_bits, pea_pkg::POS_CLR);
    wire logic [4:0] route1 = pick(setup_reg, pea_pkg::POS_OUT1);
    wire logic [4:0] route2 = pick(setup_reg, pea_pkg::POS_OUT2);
    wire logic [4:0] ev_active = cond_reg | ev_sim;

    // set wins over clear; latched flags hold until cleared
    assign flag_next = ev_active | (ev_latch & flag_reg & ~ev_clr);

    wire logic out1_next = (|route1) ? |(flag_reg & route1)
                                     : setup_reg[pea_pkg::OUT1_MANUAL_BIT];
    wire logic out2_next = (|route2) ? |(flag_reg & route2)
                                     : setup_reg[pea_pkg::OUT2_MANUAL_BIT];

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            flag_reg <= '0;
            alarm_out1_o <= 1'b0;
            alarm_out2_o <= 1'b0;
        end else begin
            flag_reg <= flag_next;
            alarm_out1_o <= out1_next;
            alarm_out2_o <= out2_next;
        end
    end

    // ========================================
    // energy counter save and restore, no event flags touched
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            pwr_reg <= pea_pkg::PWR_DOWN;
            save_start_o <= 1'b0;
            restore_start_o <= 1'b0;
        end else begin
            save_start_o <= 1'b0;
            restore_start_o <= 1'b0;
            if (calc_done_i) begin
                unique case (pwr_reg)
                    pea_pkg::PWR_DOWN: begin
                        if (volts_rms_i > restore_lvl_reg) begin
                            pwr_reg <= pea_pkg::PWR_UP;
                            restore_start_o <= 1'b1;
                        end
                    end
                    pea_pkg::PWR_UP: begin
                        if (volts_rms_i < save_lvl_reg) begin
                            pwr_reg <= pea_pkg::PWR_DOWN;
                            save_start_o <= 1'b1;
                        end
                    end
                endcase
            end
        end
    end

    // ========================================
    // register writes
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            setup_reg <= pea_pkg::SETUP_RESET;
            dip_lim_reg <= '0;
            swell_lim_reg <= '0;
            cur_lim_reg <= '0;
            pow_lim_reg <= '0;
            heat_lim_reg <= '0;
            save_lvl_reg <= '0;
            restore_lvl_reg <= '0;
        end else if (wr_go) begin
            if (awaddr_reg == pea_pkg::OFS_SETUP) begin
                setup_reg <= wr_setup & pea_pkg::SETUP_RW_MASK;
            end
            if (awaddr_reg == pea_pkg::OFS_DIP_LIM) begin
                dip_lim_reg <= merge(dip_lim_reg, wdata_reg, wstrb_reg);
            end
            if (awaddr_reg == pea_pkg::OFS_SWELL_LIM) begin
                swell_lim_reg <= merge(swell_lim_reg, wdata_reg, wstrb_reg);
            end
            if (awaddr_reg == pea_pkg::OFS_CUR_LIM) begin
                cur_lim_reg <= merge(cur_lim_reg, wdata_reg, wstrb_reg);
            end
            if (awaddr_reg == pea_pkg::OFS_POW_LIM) begin
                pow_lim_reg <= merge(pow_lim_reg, wdata_reg, wstrb_reg);
            end
            if (awaddr_reg == pea_pkg::OFS_HEAT_LIM) begin
                heat_lim_reg <= pea_pkg::HEAT_W'(merge(32'(heat_lim_reg), wdata_reg,
                                                       wstrb_reg));
            end
            if (awaddr_reg == pea_pkg::OFS_SAVE_LVL) begin
                save_lvl_reg <= merge(save_lvl_reg, wdata_reg, wstrb_reg);
            end
            if (awaddr_reg == pea_pkg::OFS_RESTORE_LVL) begin
                restore_lvl_reg <= merge(restore_lvl_reg, wdata_reg, wstrb_reg);
            end
        end
    end

    // ========================================
    // write channels: address and data taken in either order
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            awaddr_reg <= '0;
            aw_full_reg <= 1'b0;
            wdata_reg <= '0;
            wstrb_reg <= '0;
            w_full_reg <= 1'b0;
            s_axi_awready_o <= 1'b1;
            s_axi_wready_o <= 1'b1;
            s_axi_bvalid_o <= 1'b0;
            s_axi_bresp_o <= pea_pkg::RESP_OKAY;
        end else begin
            if (s_axi_awvalid_i && s_axi_awready_o) begin
                awaddr_reg <= {s_axi_awaddr_i[7:2], 2'h0};
                aw_full_reg <= 1'b1;
                s_axi_awready_o <= 1'b0;
            end
            if (s_axi_wvalid_i && s_axi_wready_o) begin
                wdata_reg <= s_axi_wdata_i;
                wstrb_reg <= s_axi_wstrb_i;
                w_full_reg <= 1'b1;
                s_axi_wready_o <= 1'b0;
            end
            if (wr_go) begin
                aw_full_reg <= 1'b0;
                w_full_reg <= 1'b0;
                s_axi_bvalid_o <= 1'b1;
                s_axi_bresp_o <= wr_mapped ? pea_pkg::RESP_OKAY : pea_pkg::RESP_SLVERR;
            end
            if (s_axi_bvalid_o && s_axi_bready_i) begin
                s_axi_bvalid_o <= 1'b0;
                s_axi_awready_o <= 1'b1;
                s_axi_wready_o <= 1'b1;
            end
        end
    end

    // ========================================
    // read decode
    wire logic [7:0] raddr = {s_axi_araddr_i[7:2], 2'h0};
    wire logic [31:0] status_word = {24'h0, pwr_reg, alarm_out2_o, alarm_out1_o, flag_reg};
    logic [31:0] rd_word;
    logic rd_ok;

    always_comb begin
        rd_word = '0;
        rd_ok = 1'b1;
        unique case (raddr)
            pea_pkg::OFS_SETUP: rd_word = setup_reg;
            pea_pkg::OFS_DIP_LIM: rd_word = dip_lim_reg;
            pea_pkg::OFS_SWELL_LIM: rd_word = swell_lim_reg;
            pea_pkg::OFS_CUR_LIM: rd_word = cur_lim_reg;
            pea_pkg::OFS_POW_LIM: rd_word = pow_lim_reg;
            pea_pkg::OFS_HEAT_LIM: rd_word = 32'(heat_lim_reg);
            pea_pkg::OFS_SAVE_LVL: rd_word = save_lvl_reg;
            pea_pkg::OFS_RESTORE_LVL: rd_word = restore_lvl_reg;
            pea_pkg::OFS_STATUS: rd_word = status_word;
            pea_pkg::OFS_MEAN: rd_word = mean_sq;
            default: rd_ok = 1'b0;
        endcase
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            s_axi_arready_o <= 1'b1;
            s_axi_rvalid_o <= 1'b0;
            s_axi_rdata_o <= '0;
            s_axi_rresp_o <= pea_pkg::RESP_OKAY;
        end else if (s_axi_arvalid_i && s_axi_arready_o) begin
            s_axi_arready_o <= 1'b0;
            s_axi_rvalid_o <= 1'b1;
            s_axi_rdata_o <= rd_word;
            s_axi_rresp_o <= rd_ok ? pea_pkg::RESP_OKAY : pea_pkg::RESP_SLVERR;
        end else if (s_axi_rvalid_o && s_axi_rready_i) begin
            s_axi_rvalid_o <= 1'b0;
            s_axi_arready_o <= 1'b1;
        end
    end

endmodule : pea_power_event_alarm_unit
`default_nettype wire

// ### verif/pea_meter_model.sv
`timescale 1ns/1ps
`default_nettype none
// ========================================
// measurement engine standing in front of the alarm unit
module pea_meter_model (
    input wire logic mclk_i,
    output logic sample_valid_o,
    output logic signed [15:0] volt_sample_o,
    output logic calc_done_o,
    output logic [31:0] volts_rms_o,
    output logic [31:0] current_rms_o,
    output logic [31:0] active_power_o,
    output logic [9:0] heat_code_o
);
    initial begin
        sample_valid_o = 1'b0;
        volt_sample_o = 16'sh0;
        calc_done_o = 1'b0;
        {volts_rms_o, current_rms_o, active_power_o, heat_code_o} = '0;
    end
    task automatic sample(input logic signed [15:0] v);
        @(posedge mclk_i);
        sample_valid_o <= 1'b1;
        volt_sample_o <= v;
        @(posedge mclk_i);
        sample_valid_o <= 1'b0;
        // stale sample line shows garbage
        volt_sample_o <= ~v;
        repeat (4) @(posedge mclk_i);
    endtask : sample
    task automatic calc(input logic [31:0] vr, ir, pw, input logic [9:0] hc);
        @(posedge mclk_i);
        calc_done_o <= 1'b1;
        {volts_rms_o, current_rms_o, active_power_o, heat_code_o} <= {vr, ir, pw, hc};
        @(posedge mclk_i);
        calc_done_o <= 1'b0;
        repeat (5) @(posedge mclk_i);
    endtask : calc
endmodule : pea_meter_model
`default_nettype wire

// ### verif/pea_unit_sva.sv
`timescale 1ns/1ps
`default_nettype none
module pea_unit_sva (
    // clock, reset, engine
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic sample_valid_i,
    input wire logic calc_done_i,
    // outputs
    input wire logic alarm_out1_o,
    input wire logic alarm_out2_o,
    input wire logic save_start_o,
    input wire logic restore_start_o,
    // bus
    input wire logic s_axi_awvalid_i,
    input wire logic s_axi_awready_o,
    input wire logic s_axi_wvalid_i,
    input wire logic s_axi_wready_o,
    input wire logic [1:0] s_axi_bresp_o,
    input wire logic s_axi_bvalid_o,
    input wire logic s_axi_arvalid_i,
    input wire logic s_axi_arready_o,
    input wire logic [31:0] s_axi_rdata_o,
    input wire logic [1:0] s_axi_rresp_o,
    input wire logic s_axi_rvalid_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);
    // ========================================
    // cycles since last cause, and power state seen from pulses
    logic [2:0] quiet_reg;
    logic up_reg;
    wire logic cause = calc_done_i | sample_valid_i | s_axi_bvalid_o
        | (s_axi_awvalid_i & s_axi_awready_o);
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            quiet_reg <= 3'h0;
            up_reg <= 1'b0;
        end else begin
            quiet_reg <= cause ? 3'h0 : quiet_reg + {2'h0, quiet_reg != 3'h7};
            up_reg <= restore_start_o | (up_reg & ~save_start_o);
        end
    end
    property p_save_pulse;
        save_start_o |-> $past(calc_done_i) && !restore_start_o ##1 !save_start_o;
    endproperty
    a_save_pulse: assert property (p_save_pulse) else $error("bad save pulse");
    property p_restore_pulse;
        restore_start_o |-> $past(calc_done_i) ##1 !restore_start_o;
    endproperty
    a_restore_pulse: assert property (p_restore_pulse) else $error("bad restore pulse");
    property p_save_hyst;
        save_start_o |-> up_reg;
    endproperty
    a_save_hyst: assert property (p_save_hyst) else $error("save while down");
    property p_restore_hyst;
        restore_start_o |-> !up_reg;
    endproperty
    a_restore_hyst: assert property (p_restore_hyst) else $error("restore while up");
    property p_out_cause;
        $changed({alarm_out2_o, alarm_out1_o}) |-> quiet_reg < 3'h5;
    endproperty
    a_out_cause: assert property (p_out_cause) else $error("output moved uncaused");
    property p_b_after_take;
        s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o
            |-> ##[1:2] s_axi_bvalid_o;
    endproperty
    a_b_after_take: assert property (p_b_after_take) else $error("no write answer");
    property p_b_readies;
        s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o;
    endproperty
    a_b_readies: assert property (p_b_readies) else $error("ready during answer");
    property p_r_after_take;
        s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o && !s_axi_arready_o;
    endproperty
    a_r_after_take: assert property (p_r_after_take) else $error("no read answer");
    property p_r_err_zero;
        s_axi_rvalid_o && s_axi_rresp_o == pea_pkg::RESP_SLVERR |-> s_axi_rdata_o == 32'h0;
    endproperty
    a_r_err_zero: assert property (p_r_err_zero) else $error("refused read data");
    c_save: cover property (save_start_o);
    c_restore: cover property (restore_start_o);
    c_out1: cover property ($rose(alarm_out1_o));
endmodule : pea_unit_sva
bind pea_power_event_alarm_unit pea_unit_sva u_sva (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
    .sample_valid_i(sample_valid_i), .calc_done_i(calc_done_i),
    .alarm_out1_o(alarm_out1_o), .alarm_out2_o(alarm_out2_o),
    .save_start_o(save_start_o), .restore_start_o(restore_start_o),
    .s_axi_awvalid_i(s_axi_awvalid_i), .s_axi_awready_o(s_axi_awready_o),
    .s_axi_wvalid_i(s_axi_wvalid_i), .s_axi_wready_o(s_axi_wready_o),
    .s_axi_bresp_o(s_axi_bresp_o), .s_axi_bvalid_o(s_axi_bvalid_o),
    .s_axi_arvalid_i(s_axi_arvalid_i), .s_axi_arready_o(s_axi_arready_o),
    .s_axi_rdata_o(s_axi_rdata_o), .s_axi_rresp_o(s_axi_rresp_o),
    .s_axi_rvalid_o(s_axi_rvalid_o));
`default_nettype wire

// ### verif/tb_power_event_alarm_unit.sv
`timescale 1ns/1ps
`default_nettype none
module tb_power_event_alarm_unit;
    localparam logic [1:0] OK = pea_pkg::RESP_OKAY;
    localparam logic [1:0] ER = pea_pkg::RESP_SLVERR;
    logic mclk = 1'b0, rst_n = 1'b0;
    logic [7:0] awaddr = 8'h0, araddr = 8'h0;
    logic [31:0] wdata = 32'h0, rdata;
    logic [3:0] wstrb = 4'hf;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, out1, out2, save, restore;
    logic sv, cd;
    logic signed [15:0] vs;
    logic [31:0] vr, ir, pw;
    logic [9:0] hc;
    logic [1:0] bresp, rresp;
    int n_errors = 0, comparisons = 0, n_save = 0, n_restore = 0;
    initial begin
        forever #2 mclk = ~mclk;
    end
    pea_meter_model u_meter (.mclk_i(mclk), .sample_valid_o(sv), .volt_sample_o(vs),
        .calc_done_o(cd), .volts_rms_o(vr), .current_rms_o(ir), .active_power_o(pw),
        .heat_code_o(hc));
    pea_power_event_alarm_unit #(.SAMPLE_RATE_HZ(400), .LINE_HZ(50)) DUT (.mclk_i(mclk),
        .rst_n_i(rst_n), .sample_valid_i(sv), .volt_sample_i(vs), .calc_done_i(cd),
        .volts_rms_i(vr), .current_rms_i(ir), .active_power_i(pw), .heat_code_i(hc),
        .alarm_out1_o(out1), .alarm_out2_o(out2), .save_start_o(save),
        .restore_start_o(restore), .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
        .s_axi_awready_o(awready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb),
        .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
        .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready), .s_axi_araddr_i(araddr),
        .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
        .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready));
    always @(posedge mclk) begin
        if (save === 1'b1) n_save++;
        if (restore === 1'b1) n_restore++;
    end
    // ========================================
    // shared tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic outs(input logic [1:0] e);
        chk({30'h0, out2, out1}, {30'h0, e});
    endtask : outs
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic aw_ok, w_ok;
        {aw_ok, w_ok} = 2'b00;
        @(posedge mclk);
        {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'b111};
        while (!(aw_ok && w_ok)) begin
            @(posedge mclk);
            if (!aw_ok && awready) begin
                aw_ok = 1'b1;
                awvalid <= 1'b0;
            end
            if (!w_ok && wready) begin
                w_ok = 1'b1;
                wvalid <= 1'b0;
            end
        end
        while (!bvalid) @(posedge mclk);
        chk({30'h0, bresp}, {30'h0, er});
        bready <= 1'b0;
        repeat (3) @(posedge mclk);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        @(posedge mclk);
        {araddr, arvalid, rready} <= {a, 2'b11};
        @(posedge mclk);
        while (!arready) @(posedge mclk);
        arvalid <= 1'b0;
        while (!rvalid) @(posedge mclk);
        chk(rdata, ed);
        chk({30'h0, rresp}, {30'h0, er});
        rready <= 1'b0;
    endtask : rd
    // ========================================
    // scenarios
    task automatic t_regs();
        rd(pea_pkg::OFS_SETUP, 32'h0, OK);
        rd(pea_pkg::OFS_STATUS, 32'h0, OK);
        wr(pea_pkg::OFS_SETUP, 32'hffffffff, OK);
        rd(pea_pkg::OFS_SETUP, 32'h1bffc0ff, OK);
        rd(pea_pkg::OFS_STATUS, 32'h7f, OK);
        wr(pea_pkg::OFS_SETUP, 32'h020000f0, OK);
        rd(pea_pkg::OFS_STATUS, 32'h1f, OK);
        wr(pea_pkg::OFS_SETUP, 32'h04000f00, OK);
        rd(pea_pkg::OFS_STATUS, 32'h0, OK);
        $display("t_regs done");
    endtask : t_regs
    task automatic t_bad();
        wr(8'h40, 32'h1, ER);
        rd(8'h40, 32'h0, ER);
        wr(pea_pkg::OFS_STATUS, 32'h1f, ER);
        rd(pea_pkg::OFS_STATUS, 32'h0, OK);
        $display("t_bad done");
    endtask : t_bad
    task automatic t_manual();
        wr(pea_pkg::OFS_SETUP, 32'h00004000, OK);
        outs(2'b01);
        wr(pea_pkg::OFS_SETUP, 32'h00008000, OK);
        outs(2'b10);
        wr(pea_pkg::OFS_SETUP, 32'h0004c000, OK);
        outs(2'b10);
        $display("t_manual done");
    endtask : t_manual
    task automatic t_current();
        wr(pea_pkg::OFS_CUR_LIM, 32'd100, OK);
        wr(pea_pkg::OFS_SETUP, 32'h00400010, OK);
        u_meter.calc(0, 100, 0, 0);
        outs(2'b00);
        u_meter.calc(0, 101, 0, 0);
        outs(2'b10);
        u_meter.calc(0, 50, 0, 0);
        outs(2'b10);
        wr(pea_pkg::OFS_SETUP, 32'h00400810, OK);
        outs(2'b00);
        rd(pea_pkg::OFS_SETUP, 32'h00400010, OK);
        $display("t_current done");
    endtask : t_current
    task automatic t_limits();
        wr(pea_pkg::OFS_POW_LIM, 32'd1000, OK);
        wr(pea_pkg::OFS_HEAT_LIM, 32'h3fe, OK);
        wr(pea_pkg::OFS_SETUP, 32'h10080000, OK);
        u_meter.calc(0, 0, 1001, 10'h3fe);
        outs(2'b01);
        u_meter.calc(0, 0, 999, 10'h3ff);
        outs(2'b10);
        $display("t_limits done");
    endtask : t_limits
    task automatic t_window();
        wr(pea_pkg::OFS_DIP_LIM, 32'd100, OK);
        wr(pea_pkg::OFS_SWELL_LIM, 32'd10000, OK);
        wr(pea_pkg::OFS_SETUP, 32'h00210000, OK);
        repeat (4) u_meter.sample(16'sd20);
        outs(2'b00);
        repeat (3) u_meter.sample(16'sd0);
        outs(2'b00);
        u_meter.sample(16'sd0);
        outs(2'b01);
        u_meter.sample(16'sd200);
        outs(2'b00);
        u_meter.sample(-16'sd200);
        outs(2'b10);
        rd(pea_pkg::OFS_MEAN, 32'd20000, OK);
        $display("t_window done");
    endtask : t_window
    task automatic t_save();
        wr(pea_pkg::OFS_SETUP, 32'h0, OK);
        wr(pea_pkg::OFS_SAVE_LVL, 32'd1000, OK);
        wr(pea_pkg::OFS_RESTORE_LVL, 32'd2000, OK);
        u_meter.calc(1500, 0, 0, 0);
        u_meter.calc(2500, 0, 0, 0);
        chk(n_restore, 1);
        rd(pea_pkg::OFS_STATUS, 32'h88, OK);
        u_meter.calc(1500, 0, 0, 0);
        chk(n_save, 0);
        u_meter.calc(900, 0, 0, 0);
        u_meter.calc(900, 0, 0, 0);
        chk(n_save, 1);
        rd(pea_pkg::OFS_STATUS, 32'h08, OK);
        $display("t_save done");
    endtask : t_save
    task automatic t_strobe();
        @(posedge mclk);
        wstrb <= 4'h5;
        wr(pea_pkg::OFS_CUR_LIM, 32'h12345678, OK);
        rd(pea_pkg::OFS_CUR_LIM, 32'h00340078, OK);
        wstrb <= 4'h2;
        wr(pea_pkg::OFS_HEAT_LIM, 32'h00000100, OK);
        rd(pea_pkg::OFS_HEAT_LIM, 32'h000001fe, OK);
        wstrb <= 4'hf;
        $display("t_strobe done");
    endtask : t_strobe
    task automatic print_verdict();
        $display("comparisons=%0d n_errors=%0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : print_verdict
    initial begin
        repeat (20000) @(posedge mclk);
        n_errors++;
        print_verdict();
    end
    initial begin
        repeat (5) @(posedge mclk);
        rst_n <= 1'b1;
        t_regs();
        t_bad();
        t_manual();
        t_current();
        t_limits();
        t_window();
        t_save();
        t_strobe();
        print_verdict();
    end
endmodule : tb_power_event_alarm_unit
`default_nettype wire
